//--- testbench/ead_decoder_asserts.sv
// assertion checker for the external area decoder
`timescale 1ns/100ps
module ead_chk (
  // clock, reset and request
  input  wire logic              SYS_CLK_I,
  input  wire logic              RESET_N_I,
  input  wire logic              REQ_VALID_I,
  input  wire ead_pkg::ead_req_t REQ_I,
  input  wire logic              REQ_DONE_O,
  input  wire logic              INTERNAL_HIT_O,
  input  wire logic              MAP_SELECT_I,
  input  wire logic              LITTLE_ENDIAN_O,
  // external pins
  input  wire logic              BUS_CYCLE_START_N_O,
  input  wire logic              AREA0_CHIP_SELECT_N_O,
  input  wire logic              AREA3_CHIP_SELECT_N_O,
  input  wire logic              AREA4_CHIP_SELECT_N_O,
  input  wire logic              AREA5_CHIP_SELECT_N_O,
  input  wire logic              AREA6_CHIP_SELECT_N_O,
  input  wire logic              RD_WR_O,
  input  wire logic              RD_N_O,
  input  wire logic              COL_STROBE_N_O,
  input  wire logic              CARD_IO16_O,
  input  wire logic [1:0]        AREA5_TYPE_I,
  input  wire logic [1:0]        AREA6_TYPE_I,
  input  wire logic              AREA5_CARD_ENABLE_HI_N_O,
  input  wire logic              AREA6_CARD_ENABLE_HI_N_O,
  input  wire logic              WAIT_N_I
);
  logic        busy_r;
  logic [31:0] addr_r;
  logic        cs_n;
  assign cs_n = &{AREA0_CHIP_SELECT_N_O, AREA3_CHIP_SELECT_N_O, AREA4_CHIP_SELECT_N_O,
                  AREA5_CHIP_SELECT_N_O, AREA6_CHIP_SELECT_N_O};
  // address of the access in flight, kept so selects can be tied to it
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      busy_r <= 1'b0;
      addr_r <= 32'h0;
    end else if (REQ_VALID_I && !busy_r) begin
      busy_r <= 1'b1;
      addr_r <= REQ_I.addr;
    end else if (REQ_DONE_O || INTERNAL_HIT_O) begin
      busy_r <= 1'b0;
    end
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_select;
    $fell(cs_n);
  endsequence
  a_select_done: assert property (s_select |-> ##[2:12] REQ_DONE_O)
    else $error("select without completion");
  a_area0_select: assert property ($fell(AREA0_CHIP_SELECT_N_O) |-> addr_r[28:26] == 3'h0)
    else $error("area 0 select on wrong address");
  a_area3_select: assert property ($fell(AREA3_CHIP_SELECT_N_O) |-> addr_r[28:26] == 3'h3)
    else $error("area 3 select on wrong address");
  a_area4_select: assert property ($fell(AREA4_CHIP_SELECT_N_O) |-> addr_r[28:26] == 3'h4)
    else $error("area 4 select on wrong address");
  a_area5_select: assert property ($fell(AREA5_CHIP_SELECT_N_O) |->
    addr_r[28:26] == 3'h5 && (MAP_SELECT_I || addr_r[25])) else $error("area 5 select wrong");
  a_area6_select: assert property ($fell(AREA6_CHIP_SELECT_N_O) |->
    addr_r[28:26] == 3'h6 && (MAP_SELECT_I || addr_r[25])) else $error("area 6 select wrong");
  a_internal_quiet: assert property (busy_r && addr_r[31:29] == 3'h7 |-> cs_n)
    else $error("select driven for internal region");
  a_start_single: assert property ($fell(BUS_CYCLE_START_N_O) |-> !cs_n ##1 BUS_CYCLE_START_N_O)
    else $error("cycle start not one cycle in select");
  a_col_start: assert property (!COL_STROBE_N_O |-> !BUS_CYCLE_START_N_O)
    else $error("column strobe without cycle start");
  a_read_dir: assert property (!RD_N_O |-> RD_WR_O)
    else $error("read strobe in write cycle");
  a_wait_hold: assert property (!cs_n && !WAIT_N_I |=> !cs_n)
    else $error("cycle ended while waiting");
  a_io16_endian: assert property (CARD_IO16_O |-> LITTLE_ENDIAN_O)
    else $error("io16 honoured in big endian");
  a_card5_enable: assert property ($fell(AREA5_CHIP_SELECT_N_O) && AREA5_TYPE_I == 2'h3
    && CARD_IO16_O |-> !AREA5_CARD_ENABLE_HI_N_O) else $error("area 5 card enable missing");
  a_card6_enable: assert property ($fell(AREA6_CHIP_SELECT_N_O) && AREA6_TYPE_I == 2'h3
    && CARD_IO16_O |-> !AREA6_CARD_ENABLE_HI_N_O) else $error("area 6 card enable missing");
endmodule
bind ead_decoder ead_chk u_chk (.*);

//--- testbench/ead_mem_model.sv
// behavioural external memory on the far side of the decoder
`timescale 1ns/100ps
module ead_mem_model (
  // strobes from the decoder
  input  wire logic        clk_i,
  input  wire logic        cs_n_i,
  input  wire logic        rd_wr_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        up_n_i,
  input  wire logic        lo_n_i,
  input  wire logic        col_n_i,
  input  wire logic [1:0]  mask_i,
  // wait length and answers
  input  wire logic [1:0]  waits_i,
  output logic [15:0]      rdata_o,
  output logic             wait_n_o
);
  logic [15:0] mem [8];
  logic [1:0]  cnt;
  initial begin
    for (int i = 0; i < 8; i++) mem[i] = 16'(16'h1111 * i);
    rdata_o = 16'h0;
    wait_n_o = 1'b1;
    cnt = 2'h0;
  end
  always @(posedge clk_i) begin
    if (!cs_n_i && !rd_wr_i && (!up_n_i || (!col_n_i && !mask_i[1]))) mem[addr_i][15:8] <= wdata_i[15:8];
    if (!cs_n_i && !rd_wr_i && (!lo_n_i || (!col_n_i && !mask_i[0]))) mem[addr_i][7:0] <= wdata_i[7:0];
  end
  // released bus toggles so stale data never looks valid
  always @(negedge clk_i) begin
    rdata_o <= (!cs_n_i && rd_wr_i) ? mem[addr_i] : ~rdata_o;
    if (cs_n_i) cnt <= 2'h0;
    else if (cnt < waits_i) cnt <= cnt + 2'h1;
    wait_n_o <= cs_n_i || cnt >= waits_i;
  end
endmodule

//--- testbench/tb_external_area_decoder.sv
// self-checking bench for the external area decoder
`timescale 1ns/100ps
module tb_external_area_decoder;
  logic SYS_CLK_I = 1'b0, RESET_N_I = 1'b0, REQ_VALID_I = 1'b0, MAP_SELECT_I = 1'b0;
  logic ENDIAN_SELECT_PIN_I = 1'b0, AREA0_WIDTH_PIN_I = 1'b0, CARD_IO16_N_I = 1'b1;
  logic [1:0] AREA3_TYPE_I = 2'h0, AREA4_TYPE_I = 2'h0, AREA5_TYPE_I = 2'h0, AREA6_TYPE_I = 2'h0;
  ead_pkg::ead_req_t REQ_I = '0;
  logic [15:0] DATA_I, DATA_O, RDATA_O;
  logic [25:0] ADDR_O;
  logic REQ_DONE_O, INTERNAL_HIT_O, RESERVED_HIT_O, LITTLE_ENDIAN_O, AREA0_BUS8_O, DATA_OE_N_O;
  logic BUS_CYCLE_START_N_O, AREA0_CHIP_SELECT_N_O, AREA3_CHIP_SELECT_N_O, AREA4_CHIP_SELECT_N_O;
  logic AREA5_CHIP_SELECT_N_O, AREA5_CARD_ENABLE_HI_N_O, AREA6_CHIP_SELECT_N_O, RD_WR_O, RD_N_O;
  logic AREA6_CARD_ENABLE_HI_N_O, UPPER_LANE_WRITE_N_O, LOWER_LANE_WRITE_N_O, ROW_STROBE_N_O;
  logic COL_STROBE_N_O, CLOCK_ENABLE_O, SDRAM_UPPER_MASK_O, SDRAM_LOWER_MASK_O, CARD_IO16_O, WAIT_N_I;
  logic [1:0] waits = 2'h0;
  logic       ihit;
  int         miscompares = 0, check_count = 0, seed;
  int         em [8];
  int         base [5] = '{32'h0, 32'h0c000000, 32'h10000000, 32'h16000000, 32'h1a000000};
  ead_decoder u_dut (.*);
  ead_mem_model u_mem (.clk_i(SYS_CLK_I), .cs_n_i(&{AREA0_CHIP_SELECT_N_O, AREA3_CHIP_SELECT_N_O,
    AREA4_CHIP_SELECT_N_O, AREA5_CHIP_SELECT_N_O, AREA6_CHIP_SELECT_N_O}), .rd_wr_i(RD_WR_O),
    .addr_i(ADDR_O[3:1]), .wdata_i(DATA_O), .up_n_i(UPPER_LANE_WRITE_N_O),
    .lo_n_i(LOWER_LANE_WRITE_N_O), .col_n_i(COL_STROBE_N_O),
    .mask_i({SDRAM_UPPER_MASK_O, SDRAM_LOWER_MASK_O}), .waits_i(waits), .rdata_o(DATA_I),
    .wait_n_o(WAIT_N_I));
  always #50 SYS_CLK_I = ~SYS_CLK_I;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic do_reset(input logic e, input logic w);
    RESET_N_I = 1'b0;
    ENDIAN_SELECT_PIN_I = e;
    AREA0_WIDTH_PIN_I = w;
    repeat (6) @(negedge SYS_CLK_I);
    RESET_N_I = 1'b1;
    repeat (5) @(negedge SYS_CLK_I);
  endtask
  // request held until the completion or internal-hit answer
  task automatic acc(input logic [31:0] a, input logic wr, input logic [1:0] ln,
                     input logic [15:0] d);
    int n;
    n = 0;
    REQ_I = '{a, wr, ln, d};
    REQ_VALID_I = 1'b1;
    do begin
      @(negedge SYS_CLK_I);
      n++;
    end while (!REQ_DONE_O && !INTERNAL_HIT_O && n < 30);
    ihit = INTERNAL_HIT_O;
    REQ_VALID_I = 1'b0;
    @(negedge SYS_CLK_I);
    if (n >= 30) chk(16'h0, 16'h1);
  endtask
  // never aims at reserved areas or area 7
  task automatic wr_rd(input logic [31:0] b, input logic m);
    logic [31:0] a;
    logic [15:0] d;
    int          msk;
    a = b + 32'h20000000 * $urandom_range(6, 0) + 32'(2 * $urandom_range(7, 0));
    d = 16'($urandom);
    msk = $urandom_range(3, 1);
    MAP_SELECT_I = m;
    waits = 2'($urandom_range(3, 0));
    acc(a, 1'b1, 2'(msk), d);
    msk = (msk[1] ? 32'hff00 : 0) | (msk[0] ? 32'h00ff : 0);
    em[a[3:1]] = (em[a[3:1]] & ~msk) | (int'(d) & msk);
    acc(a, 1'b0, 2'h3, 16'h0);
    chk(RDATA_O, 16'(em[a[3:1]]));
  endtask
  initial begin
    seed = $urandom(32'h22bdb78a);
    for (int i = 0; i < 8; i++) em[i] = i * 32'h1111;
    do_reset(1'b0, 1'b0);
    chk({13'h0, LITTLE_ENDIAN_O, AREA0_BUS8_O, CARD_IO16_O}, 16'h0);
    for (int t = 0; t < 4; t++) begin
      AREA3_TYPE_I = (t == 3) ? 2'h2 : 2'(t);
      AREA4_TYPE_I = 2'(t % 2);
      AREA5_TYPE_I = (t == 3) ? 2'h3 : 2'(t % 2);
      AREA6_TYPE_I = AREA5_TYPE_I;
      for (int k = 0; k < 6; k++) wr_rd(k == 5 ? 32'h14000000 : base[k], k == 5);
    end
    acc(32'he0000010, 1'b0, 2'h3, 16'h0);
    chk({15'h0, ihit}, 16'h1);
    do_reset(1'b1, 1'b1);
    CARD_IO16_N_I = 1'b0;
    repeat (2) @(negedge SYS_CLK_I);
    chk({13'h0, LITTLE_ENDIAN_O, AREA0_BUS8_O, CARD_IO16_O}, 16'h7);
    AREA5_TYPE_I = 2'h3;
    AREA6_TYPE_I = 2'h3;
    for (int k = 3; k < 6; k++) wr_rd(k == 5 ? 32'h18000000 : base[k], k == 5);
    complete_run();
  end
  initial begin
    #3000000;
    miscompares++;
    complete_run();
  end
endmodule

//--- verilog/ead_decoder.sv
// external area decoder and external strobe generator
`timescale 1ns/100ps
module ead_decoder (
  // clock and reset
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  RESET_N_I,
  // internal master request
  input  wire logic                  REQ_VALID_I,
  input  wire ead_pkg::ead_req_t     REQ_I,
  output logic                       REQ_DONE_O,
  output logic [15:0]                RDATA_O,
  output logic                       INTERNAL_HIT_O,
  output logic                       RESERVED_HIT_O,
  // configuration
  input  wire logic                  MAP_SELECT_I,
  input  wire logic [1:0]            AREA3_TYPE_I,
  input  wire logic [1:0]            AREA4_TYPE_I,
  input  wire logic [1:0]            AREA5_TYPE_I,
  input  wire logic [1:0]            AREA6_TYPE_I,
  input  wire logic                  ENDIAN_SELECT_PIN_I,
  input  wire logic                  AREA0_WIDTH_PIN_I,
  output logic                       LITTLE_ENDIAN_O,
  output logic                       AREA0_BUS8_O,
  // external pins
  output logic [25:0]                ADDR_O,
  input  wire logic [15:0]           DATA_I,
  output logic [15:0]                DATA_O,
  output logic                       DATA_OE_N_O,
  output logic                       BUS_CYCLE_START_N_O,
  output logic                       AREA0_CHIP_SELECT_N_O,
  output logic                       AREA3_CHIP_SELECT_N_O,
  output logic                       AREA4_CHIP_SELECT_N_O,
  output logic                       AREA5_CHIP_SELECT_N_O,
  output logic                       AREA5_CARD_ENABLE_HI_N_O,
  output logic                       AREA6_CHIP_SELECT_N_O,
  output logic                       AREA6_CARD_ENABLE_HI_N_O,
  output logic                       RD_WR_O,
  output logic                       RD_N_O,
  output logic                       UPPER_LANE_WRITE_N_O,
  output logic                       LOWER_LANE_WRITE_N_O,
  output logic                       ROW_STROBE_N_O,
  output logic                       COL_STROBE_N_O,
  output logic                       CLOCK_ENABLE_O,
  output logic                       SDRAM_UPPER_MASK_O,
  output logic                       SDRAM_LOWER_MASK_O,
  input  wire logic                  CARD_IO16_N_I,
  output logic                       CARD_IO16_O,
  input  wire logic                  WAIT_N_I
);

  typedef enum logic [1:0] {EAD_IDLE, EAD_START, EAD_ACCESS, EAD_END} ead_state_t;

  logic       rst_meta_r, rst_sync_r;
  logic       strap_done_r;
  ead_state_t state_r;
  ead_pkg::ead_req_t req_r;
  ead_pkg::ead_hit_t hit;
  ead_pkg::ead_mem_t mem;
  logic       card_io16;

  // area decode from address bits 28..25, with bits 31..29 checked only for the internal region
  function automatic ead_pkg::ead_hit_t decode(input logic [31:0] a, input logic map2);
    ead_pkg::ead_hit_t h;
    logic [3:0] sel;
    h   = '0;
    sel = a[ead_pkg::AREA_MSB:ead_pkg::AREA_LSB];
    if (a[31:29] == ead_pkg::INTREG_TOP) begin
      h.reserved = 1'b0;
    end else begin
      unique case (sel[3:1])
        3'h0: h.a0 = 1'b1;
        3'h1: h.reserved = 1'b1;
        3'h2: h.reserved = 1'b1;
        3'h3: h.a3 = 1'b1;
        3'h4: h.a4 = 1'b1;
        3'h5: begin
          h.a5       = map2 | sel[0];
          h.reserved = ~map2 & ~sel[0];
        end
        3'h6: begin
          h.a6       = map2 | sel[0];
          h.reserved = ~map2 & ~sel[0];
        end
        3'h7: h.reserved = 1'b1;
      endcase
    end
    return h;
  endfunction

  // a reset copy through two flops
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // mode straps caught on the first edge after release
  always_ff @(posedge SYS_CLK_I or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      strap_done_r    <= 1'b0;
      LITTLE_ENDIAN_O <= 1'b0;
      AREA0_BUS8_O    <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r    <= 1'b1;
      LITTLE_ENDIAN_O <= ENDIAN_SELECT_PIN_I;
      AREA0_BUS8_O    <= AREA0_WIDTH_PIN_I;
    end
  end

  assign hit = decode(req_r.addr, MAP_SELECT_I);
  // io16 ignored in big endian; system keeps it low there anyway
  assign card_io16 = LITTLE_ENDIAN_O & ~CARD_IO16_N_I;

  always_comb begin
    mem = ead_pkg::EAD_MEM_NORMAL;
    if (hit.a3) mem = ead_pkg::ead_mem_t'({1'b0, AREA3_TYPE_I});
    if (hit.a4) mem = ead_pkg::ead_mem_t'({1'b0, AREA4_TYPE_I});
    if (hit.a5) mem = ead_pkg::ead_mem_t'({1'b0, AREA5_TYPE_I});
    if (hit.a6) mem = ead_pkg::ead_mem_t'({1'b0, AREA6_TYPE_I});
  end

  // access sequencer
  always_ff @(posedge SYS_CLK_I or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= EAD_IDLE;
      req_r   <= '0;
    end else begin
      unique case (state_r)
        EAD_IDLE: if (REQ_VALID_I && strap_done_r) begin
          req_r   <= REQ_I;
          state_r <= EAD_START;
        end
        EAD_START:  state_r <= EAD_ACCESS;
        EAD_ACCESS: if (WAIT_N_I) state_r <= EAD_END;
        EAD_END:    state_r <= EAD_IDLE;
      endcase
    end
  end

  // pin drive, all from flops
  always_ff @(posedge SYS_CLK_I or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ADDR_O <= '0;
      DATA_O <= '0;
      DATA_OE_N_O <= 1'b1;
      BUS_CYCLE_START_N_O <= 1'b1;
      AREA0_CHIP_SELECT_N_O <= 1'b1;
      AREA3_CHIP_SELECT_N_O <= 1'b1;
      AREA4_CHIP_SELECT_N_O <= 1'b1;
      AREA5_CHIP_SELECT_N_O <= 1'b1;
      AREA5_CARD_ENABLE_HI_N_O <= 1'b1;
      AREA6_CHIP_SELECT_N_O <= 1'b1;
      AREA6_CARD_ENABLE_HI_N_O <= 1'b1;
      RD_WR_O <= 1'b1;
      RD_N_O <= 1'b1;
      UPPER_LANE_WRITE_N_O <= 1'b1;
      LOWER_LANE_WRITE_N_O <= 1'b1;
      ROW_STROBE_N_O <= 1'b1;
      COL_STROBE_N_O <= 1'b1;
      CLOCK_ENABLE_O <= 1'b0;
      SDRAM_UPPER_MASK_O <= 1'b1;
      SDRAM_LOWER_MASK_O <= 1'b1;
      CARD_IO16_O <= 1'b0;
      REQ_DONE_O <= 1'b0;
      RDATA_O <= '0;
      INTERNAL_HIT_O <= 1'b0;
      RESERVED_HIT_O <= 1'b0;
    end else begin
      logic active;
      logic is_card;
      active  = (state_r == EAD_ACCESS) || (state_r == EAD_START);
      is_card = (mem == ead_pkg::EAD_MEM_CARD);
      CLOCK_ENABLE_O <= 1'b1;
      REQ_DONE_O <= (state_r == EAD_END);
      INTERNAL_HIT_O <= (state_r == EAD_START) && (req_r.addr[31:29] == ead_pkg::INTREG_TOP);
      RESERVED_HIT_O <= (state_r == EAD_START) && hit.reserved;
      CARD_IO16_O <= card_io16;
      ADDR_O <= req_r.addr[ead_pkg::ADDR_W-1:0];
      DATA_O <= req_r.wdata;
      DATA_OE_N_O <= ~(active && req_r.write);
      if (state_r == EAD_ACCESS && WAIT_N_I && !req_r.write) RDATA_O <= DATA_I;
      // reserved and internal hits drive no chip select, cycle start or column strobe; the read, write, lane and mask strobes still follow the state
      AREA0_CHIP_SELECT_N_O <= ~(active && hit.a0);
      AREA3_CHIP_SELECT_N_O <= ~(active && hit.a3);
      AREA4_CHIP_SELECT_N_O <= ~(active && hit.a4);
      AREA5_CHIP_SELECT_N_O <= ~(active && hit.a5);
      AREA6_CHIP_SELECT_N_O <= ~(active && hit.a6);
      AREA5_CARD_ENABLE_HI_N_O <= ~(active && hit.a5 && is_card && card_io16);
      AREA6_CARD_ENABLE_HI_N_O <= ~(active && hit.a6 && is_card && card_io16);
      BUS_CYCLE_START_N_O <= ~(state_r == EAD_START && !hit.reserved
                               && (hit.a0 | hit.a3 | hit.a4 | hit.a5 | hit.a6));
      ROW_STROBE_N_O <= ~(state_r == EAD_IDLE && REQ_VALID_I && 1'b0);
      COL_STROBE_N_O <= ~(state_r == EAD_START && mem == ead_pkg::EAD_MEM_SDRAM);
      RD_WR_O <= ~(active && req_r.write);
      RD_N_O <= ~(state_r == EAD_ACCESS && !req_r.write);
      UPPER_LANE_WRITE_N_O <= ~(state_r == EAD_ACCESS && req_r.write && req_r.lanes[1]);
      LOWER_LANE_WRITE_N_O <= ~(state_r == EAD_ACCESS && req_r.write && req_r.lanes[0]);
      SDRAM_UPPER_MASK_O <= ~(active && req_r.lanes[1]);
      SDRAM_LOWER_MASK_O <= ~(active && req_r.lanes[0]);
    end
  end

endmodule

//--- verilog/ead_pkg.sv
// constants, types and functional notes for the external area decoder
// Functional notes
// - area chosen from address bits 28..25; bits 31..29 ignored below 0xe0000000
// - address plus 0x20000000 times n (n 1..6) hits same area
// - top region from 0xe0000000 is internal registers, never a shadow
// - map 1: ten areas, five reserved; map 2: eight areas, three reserved
// - five separate active-low chip selects for areas 0, 3, 4, 5, 6
// - area 0 chip select active for every area 0 access
// - map 1 areas 0, 3, 4 are 64 Mbytes each with listed memory types
// - map 1 areas 5B, 6B are 32 Mbytes; 5A and 6A reserved
// - cycle start for normal, burst rom, card; with column strobe on sdram
// - read/write output serves as sdram or byte-sram write enable
// - read strobe pulses for card memory reads
// - upper lane write strobe marks D15..D8 writes, byte select, card write
// - lower lane write strobe marks D7..D0 writes, byte select
// - sdram upper mask selects D15..D8, lower mask D7..D0
// - card enables for areas 5 and 6 share pins with chip selects
// - 16-bit card io input honoured only in little endian
// - endianness taken from the endian-select pin
// - area 0 bus width taken from the bus-width pin
// - width pin sampled at reset: high 8-bit, low 16-bit
// - endian pin sampled at reset: low big, high little
// - map-select control bit 12: 0 first map, 1 second map
package ead_pkg;
  localparam int ADDR_W       = 26;
  localparam int DATA_W       = 16;
  localparam int AREA_LSB     = 25;
  localparam int AREA_MSB     = 28;
  localparam int MAP_BIT      = 12;
  localparam logic [2:0] INTREG_TOP = 3'h7;
  localparam logic [31:0] INTREG_BASE = 32'he0000000;

  typedef enum logic [2:0] {
    EAD_MEM_NORMAL, EAD_MEM_BSRAM, EAD_MEM_SDRAM, EAD_MEM_CARD
  } ead_mem_t;

  typedef struct packed {
    logic       a0, a3, a4, a5, a6;
    logic       reserved;
  } ead_hit_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [1:0]  lanes;
    logic [15:0] wdata;
  } ead_req_t;
endpackage
